// [pkg/vid_seq_pkg.sv]
// shared constants, types and decode functions of the reference sequencer
// assumes one 200 MHz clock; timing counts mclk clocks, or sample ticks and switching cycles built from it
package vid_seq_pkg;

  // ----------------------------------------------------------------
  // code and level
  // ----------------------------------------------------------------
  localparam int          CODE_W          = 6;
  localparam int          LVL_W           = 8;
  localparam logic [5:0]  CODE_OFF_A      = 6'h3F;
  localparam logic [5:0]  CODE_OFF_B      = 6'h3E;
  localparam logic [5:0]  CODE_SPLIT      = 6'h15;
  localparam logic [7:0]  LVL_BASE_LO     = 8'h57;
  localparam logic [7:0]  LVL_BASE_HI     = 8'h95;

  // ----------------------------------------------------------------
  // timing, in mclk clocks, sample ticks and switching cycles
  // ----------------------------------------------------------------
  localparam logic [7:0]  SIXTH_LEN_RST   = 8'h43;
  localparam logic [2:0]  LAST_SAMPLE     = 3'h5;
  localparam logic [1:0]  HALF_WAIT_LAST  = 2'h2;
  localparam logic [15:0] SS_DELAY_LAST   = 16'h003F;
  localparam logic [15:0] FAST_CYC        = 16'h0280;
  localparam logic [4:0]  FAST_STEP_LAST  = 5'h1F;
  localparam logic [3:0]  SLOW_STEP_LAST  = 4'hF;
  localparam logic [6:0]  OFS_STEP_LAST   = 7'h4F;
  localparam logic [3:0]  OFS_START       = 4'h8;
  localparam logic [7:0]  FAST_STEP       = 8'h02;
  localparam logic [7:0]  SLOW_STEP       = 8'h01;
  localparam logic [1:0]  NOLOAD_CYC      = 2'h2;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam int          ADDR_W          = 4;
  localparam logic [3:0]  ADDR_CTRL       = 4'h0;
  localparam logic [3:0]  ADDR_STATUS     = 4'h4;
  localparam logic [3:0]  ADDR_LEVEL      = 4'h8;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {ST_SHUT, ST_NOLOAD, ST_DELAY, ST_RAMP, ST_RUN} state_e;

  typedef struct packed {
    logic       porValid;
    logic       enThreshold;
    logic       logicLevelEnableInput;
    logic       refReachedOutput;
    logic       outputInWindow;
    logic       ovTrip;
    logic [5:0] voltageCodeInput;
  } pins_s;

  typedef struct packed {
    logic [3:0]  addr;
    logic [31:0] wrData;
    logic        wrStrobe;
    logic        rdStrobe;
  } bus_req_s;

  // ----------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------
  function automatic logic isNoLoad(input logic [5:0] code);
    return (code == CODE_OFF_A) || (code == CODE_OFF_B);
  endfunction

  function automatic logic [7:0] codeLevel(input logic [5:0] code);
    if (isNoLoad(code))
      return 8'h00;
    else if (code < CODE_SPLIT)
      return LVL_BASE_LO - {2'b00, code};
    else
      return LVL_BASE_HI - {2'b00, code};
  endfunction

endpackage

// [rtl/pin_sync.sv]
// three-stage synchroniser for pin inputs
// assumes inputs asynchronous to mclk; output moves when stages two and three agree
`timescale 1ns/10ps
module pin_sync
#(
  parameter int W = 12
)
(
  // clock and reset
  input  wire logic         mclk,
  input  wire logic         rst,
  // pins in, filtered value out
  input  wire logic [W-1:0] pinIn,
  output logic      [W-1:0] pinOut
);

  logic [W-1:0] stage1;
  logic [W-1:0] stage2;
  logic [W-1:0] stage3;

  // ----------------------------------------------------------------
  // three flops, change taken when two and three agree
  // ----------------------------------------------------------------
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      stage1 <= '0;
      stage2 <= '0;
      stage3 <= '0;
      pinOut <= '0;
    end
    else
    begin
      stage1 <= pinIn;
      stage2 <= stage1;
      stage3 <= stage2;
      for (int i = 0; i < W; i++)
      begin
        if (stage2[i] == stage3[i])
          pinOut[i] <= stage3[i];
      end
    end
  end

endmodule

// [rtl/vid_softstart_sequencer.sv]
// soft-start and code-tracking sequencer of a multi-phase buck controller
// assumes comparator and code pins arrive asynchronously; power-on reset drives rst
//
// Notes on behaviour
// - the 6-bit code decodes to a level in 12.5mV units; two codes mean no load.
// - the code is sampled six times in each switching cycle.
// - a changed code waits half a cycle, then the reference moves one step.
// - if the difference changes during that wait, no step is made.
// - more than one step apart, the reference steps six times per cycle until one step apart; the last step waits half a cycle.
// - in shutdown every PWM output stays high impedance.
// - leave shutdown only with reset valid, both enables high and a load code.
// - soft start begins at once when all enable conditions hold.
// - a no-load code shuts down; any other code then reruns soft start.
// - after a no-load code wait two cycles, then raise trip level and stop PWM.
// - a latched overvoltage shutdown is never cleared by a code change.
// - soft start ramps the reference from zero to the requested level.
// - PWM stays high impedance until the ramp reaches the output voltage.
// - soft start opens with 64 cycles delay, then 1280 cycles per volt.
// - a 100mV sense offset falls to zero over the first 640 ramp cycles.
// - the first 640 ramp cycles step 25mV, the rest 12.5mV.
// - power good rises after soft start while the output is in window.
// - power good is low in shutdown and on any disable.
//
// Our own choices: the register addresses and the plain strobed port.
`timescale 1ns/10ps
module vid_softstart_sequencer
  import vid_seq_pkg::*;
(
  // clock and reset
  input  wire logic                 mclk,
  input  wire logic                 rst,
  // pins and comparators
  input  wire vid_seq_pkg::pins_s   pins,
  // register port
  input  wire vid_seq_pkg::bus_req_s busReq,
  output logic [31:0]               rdData,
  // converter outputs
  output logic                      pwmOe_n,
  output logic                      powerGoodOutput,
  output logic                      ovLevelShutdown,
  output logic [3:0]                rsOffset,
  output logic [7:0]                refLevel
);

  import vid_seq_pkg::*;

  pins_s       syncPins;
  state_e      state;
  logic [7:0]  sixthLen;
  logic [7:0]  sixthCnt;
  logic [2:0]  sampleIdx;
  logic        sampleTick;
  logic        cycleTick;
  logic [5:0]  sampCode;
  logic [7:0]  targetLvl;
  logic        noLoad;
  logic        enableOk;
  logic        ovLatched;
  logic [15:0] ssCnt;
  logic [6:0]  ofsCnt;
  logic [1:0]  nlCnt;
  logic        waiting;
  logic [1:0]  waitCnt;
  logic [8:0]  savedDiff;
  logic [8:0]  diff;
  logic        trackUp;
  logic        trackDn;
  logic        startOk;

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  pin_sync #(.W($bits(pins_s))) u_sync
  (
    .mclk   (mclk),
    .rst    (rst),
    .pinIn  (pins),
    .pinOut (syncPins)
  );

  // ----------------------------------------------------------------
  // switching-cycle timebase, six sample ticks per cycle
  // ----------------------------------------------------------------
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      sixthCnt   <= 8'h00;
      sampleIdx  <= 3'h0;
      sampleTick <= 1'b0;
      cycleTick  <= 1'b0;
    end
    else
    begin
      sampleTick <= 1'b0;
      cycleTick  <= 1'b0;
      if (sixthCnt + 8'h01 >= sixthLen)
      begin
        sixthCnt   <= 8'h00;
        sampleTick <= 1'b1;
        if (sampleIdx == LAST_SAMPLE)
        begin
          sampleIdx <= 3'h0;
          cycleTick <= 1'b1;
        end
        else
          sampleIdx <= sampleIdx + 3'h1;
      end
      else
        sixthCnt <= sixthCnt + 8'h01;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
      sampCode <= CODE_OFF_A;
    else if (sampleTick)
      sampCode <= syncPins.voltageCodeInput;
  end

  always_comb
  begin
    targetLvl = codeLevel(sampCode);
    noLoad    = isNoLoad(sampCode);
    enableOk  = syncPins.porValid && syncPins.enThreshold && syncPins.logicLevelEnableInput;
    startOk   = enableOk && !noLoad && !ovLatched;
    diff      = {1'b0, targetLvl} - {1'b0, refLevel};
  end

  // ----------------------------------------------------------------
  // overvoltage latch
  // ----------------------------------------------------------------
  // cleared only by an enable drop
  always_ff @(posedge mclk)
  begin
    if (rst)
      ovLatched <= 1'b0;
    else if (syncPins.ovTrip && syncPins.porValid)
      ovLatched <= 1'b1;
    else if (!enableOk)
      ovLatched <= 1'b0;
  end

  // ----------------------------------------------------------------
  // sequencing state and counters
  // ----------------------------------------------------------------
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      state <= ST_SHUT;
      ssCnt <= 16'h0000;
      nlCnt <= 2'h0;
    end
    else if (state != ST_SHUT && (!enableOk || ovLatched))
      state <= ST_SHUT;
    else
    begin
      unique case (state)
        ST_SHUT:
          if (startOk)
          begin
            state <= ST_DELAY;
            ssCnt <= 16'h0000;
          end
        ST_NOLOAD:
          if (cycleTick)
          begin
            if (nlCnt == NOLOAD_CYC)
              state <= ST_SHUT;
            else
              nlCnt <= nlCnt + 2'h1;
          end
        ST_DELAY, ST_RAMP, ST_RUN:
          if (noLoad)
          begin
            state <= ST_NOLOAD;
            nlCnt <= 2'h0;
          end
          else if (state == ST_DELAY && cycleTick)
          begin
            if (ssCnt == SS_DELAY_LAST)
            begin
              state <= ST_RAMP;
              ssCnt <= 16'h0000;
            end
            else
              ssCnt <= ssCnt + 16'h0001;
          end
          else if (state == ST_RAMP)
          begin
            if (refLevel >= targetLvl)
              state <= ST_RUN;
            else if (cycleTick && ssCnt != 16'hFFFF)
              ssCnt <= ssCnt + 16'h0001;
          end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // sense-amplifier offset
  // ----------------------------------------------------------------
  // 100mV offset falls over 640 cycles
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      rsOffset <= 4'h0;
      ofsCnt   <= 7'h00;
    end
    else if (state == ST_SHUT)
    begin
      rsOffset <= startOk ? OFS_START : 4'h0;
      ofsCnt   <= 7'h00;
    end
    else if (state == ST_RAMP && cycleTick && rsOffset != 4'h0)
    begin
      if (ofsCnt == OFS_STEP_LAST)
      begin
        ofsCnt   <= 7'h00;
        rsOffset <= rsOffset - 4'h1;
      end
      else
        ofsCnt <= ofsCnt + 7'h01;
    end
  end

  // ----------------------------------------------------------------
  // dynamic code tracker
  // ----------------------------------------------------------------
  // tracking only in run
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      waiting   <= 1'b0;
      waitCnt   <= 2'h0;
      savedDiff <= 9'h000;
    end
    else if (state != ST_RUN || !sampleTick || diff == 9'h000)
    begin
      if (state != ST_RUN || diff == 9'h000)
        waiting <= 1'b0;
    end
    else if (diff != 9'h001 && diff != 9'h1FF)
      waiting <= 1'b0;
    else if (!waiting)
    begin
      waiting   <= 1'b1;
      waitCnt   <= 2'h0;
      savedDiff <= diff;
    end
    else if (diff != savedDiff || waitCnt == HALF_WAIT_LAST)
      waiting <= 1'b0;
    else
      waitCnt <= waitCnt + 2'h1;
  end

  always_comb
  begin
    trackUp = 1'b0;
    trackDn = 1'b0;
    if (state == ST_RUN && sampleTick && diff != 9'h000)
    begin
      // wide jumps slew six steps per cycle
      if (diff != 9'h001 && diff != 9'h1FF)
      begin
        trackUp = !diff[8];
        trackDn = diff[8];
      end
      else if (waiting && waitCnt == HALF_WAIT_LAST && diff == savedDiff)
      begin
        trackUp = !diff[8];
        trackDn = diff[8];
      end
    end
  end

  // ----------------------------------------------------------------
  // reference level
  // ----------------------------------------------------------------
  always_ff @(posedge mclk)
  begin
    if (rst)
      refLevel <= 8'h00;
    else if (state == ST_SHUT)
      refLevel <= 8'h00;
    else if (state == ST_RAMP && cycleTick && refLevel < targetLvl)
    begin
      if (ssCnt < FAST_CYC && ssCnt[4:0] == FAST_STEP_LAST)
        refLevel <= (targetLvl - refLevel <= FAST_STEP) ? targetLvl : refLevel + FAST_STEP;
      else if (ssCnt >= FAST_CYC && ssCnt[3:0] == SLOW_STEP_LAST)
        refLevel <= refLevel + SLOW_STEP;
    end
    else if (trackUp)
      refLevel <= refLevel + SLOW_STEP;
    else if (trackDn)
      refLevel <= refLevel - SLOW_STEP;
  end

  // ----------------------------------------------------------------
  // pwm release, trip level and power good
  // ----------------------------------------------------------------
  always_ff @(posedge mclk)
  begin
    if (rst)
      pwmOe_n <= 1'b1;
    else if (state == ST_SHUT || state == ST_DELAY)
      pwmOe_n <= 1'b1;
    // release once the ramp meets the output
    else if (state == ST_RAMP && syncPins.refReachedOutput)
      pwmOe_n <= 1'b0;
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
      ovLevelShutdown <= 1'b0;
    else if (state == ST_NOLOAD && cycleTick && nlCnt == NOLOAD_CYC)
      ovLevelShutdown <= 1'b1;
    else if (state != ST_SHUT && state != ST_NOLOAD)
      ovLevelShutdown <= 1'b0;
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
      powerGoodOutput <= 1'b0;
    else
      powerGoodOutput <= (state == ST_RUN) && !noLoad && enableOk && syncPins.outputInWindow;
  end

  // ----------------------------------------------------------------
  // register port
  // ----------------------------------------------------------------
  always_ff @(posedge mclk)
  begin
    if (rst)
      sixthLen <= SIXTH_LEN_RST;
    else if (busReq.wrStrobe && busReq.addr == ADDR_CTRL)
      sixthLen <= busReq.wrData[7:0];
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
      rdData <= 32'h0000_0000;
    else if (!busReq.rdStrobe)
      rdData <= 32'h0000_0000;
    else
    begin
      unique case (busReq.addr)
        ADDR_CTRL:   rdData <= {24'h000000, sixthLen};
        ADDR_STATUS: rdData <= {20'h00000, rsOffset, 1'b0, state, ovLatched, ovLevelShutdown,
                                powerGoodOutput, !pwmOe_n};
        ADDR_LEVEL:  rdData <= {10'h000, sampCode, targetLvl, refLevel};
        default:     rdData <= 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  shut_hiz_a: assert property (@(posedge mclk) disable iff (rst)
    (state == ST_SHUT) |=> pwmOe_n) else $error("pwm driven in shutdown");

  enable_gate_a: assert property (@(posedge mclk) disable iff (rst)
    (state == ST_SHUT && !startOk) |=> (state == ST_SHUT)) else $error("left shutdown without enables");

  start_now_a: assert property (@(posedge mclk) disable iff (rst)
    (state == ST_SHUT && startOk) |=> (state == ST_DELAY)) else $error("soft start delayed");

  noload_hold_a: assert property (@(posedge mclk) disable iff (rst)
    (state == ST_NOLOAD && nlCnt < NOLOAD_CYC && enableOk && !ovLatched)
      |=> (state == ST_NOLOAD && !ovLevelShutdown)) else $error("no-load hold cut short");

  ov_hold_a: assert property (@(posedge mclk) disable iff (rst)
    (ovLatched && enableOk) |=> ovLatched) else $error("overvoltage latch cleared by code");

  fast_step_a: assert property (@(posedge mclk) disable iff (rst)
    (state == ST_RAMP && cycleTick && ssCnt < FAST_CYC && ssCnt[4:0] == FAST_STEP_LAST
     && refLevel + FAST_STEP <= targetLvl && enableOk && !ovLatched && !noLoad)
      |=> (refLevel == $past(refLevel) + FAST_STEP)) else $error("fast ramp step wrong");

  offset_zero_a: assert property (@(posedge mclk) disable iff (rst)
    (state == ST_RAMP && ssCnt >= FAST_CYC) |-> (rsOffset == 4'h0)) else $error("offset left after 640");

  ramp_only_a: assert property (@(posedge mclk) disable iff (rst)
    (state == ST_RAMP && !cycleTick) |=> (refLevel == $past(refLevel))) else $error("ramp moved off tick");

  track_step_a: assert property (@(posedge mclk) disable iff (rst)
    (state == ST_RUN && $past(state) == ST_RUN)
      |-> (refLevel == $past(refLevel) || refLevel == $past(refLevel) + 8'h01
           || refLevel == $past(refLevel) - 8'h01)) else $error("tracking jumped more than one step");

  power_good_output_low_a: assert property (@(posedge mclk) disable iff (rst)
    (state != ST_RUN) |=> !powerGoodOutput) else $error("power good high outside run");

  run_reached_c: cover property (@(posedge mclk) disable iff (rst)
    (state == ST_RAMP) ##1 (state == ST_RUN));
  noload_shut_c: cover property (@(posedge mclk) disable iff (rst)
    (state == ST_NOLOAD) ##1 (state == ST_SHUT && ovLevelShutdown));
  track_up_c: cover property (@(posedge mclk) disable iff (rst)
    (state == ST_RUN && trackUp));

endmodule

// [bench/code_source_model.sv]
// processor side model driving the code pins
// assumes the bench gives the wanted code and a jump pulse on mclk
`timescale 1ns/10ps
module code_source_model
#(
  parameter int GAP = 200
)
(
  // clock and reset
  input  wire logic       mclk,
  input  wire logic       rst,
  // wanted code and direct jump
  input  wire logic [5:0] reqCode,
  input  wire logic       jump,
  // code pins
  output logic      [5:0] code
);
  int gap;

  // ----------------------------------------------------------------
  // code pacing
  // ----------------------------------------------------------------
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      code <= 6'h3F;
      gap  <= 0;
    end
    else if (jump)
      code <= reqCode;
    else if (gap != 0)
      gap <= gap - 1;
    else if (code != reqCode)
    begin
      code <= (code < reqCode) ? code + 6'h01 : code - 6'h01;
      gap  <= GAP;
    end
  end
endmodule

// [bench/vid_softstart_sequencer_test.sv]
// self-checking bench of the reference sequencer
// assumes the code source model on the code pins and a 200 MHz clock
`timescale 1ns/10ps
module vid_softstart_sequencer_test;
  import vid_seq_pkg::*;
  logic        mclk    = 1'b0;
  logic        rst     = 1'b1;
  logic        por     = 1'b0;
  logic        enTh    = 1'b0;
  logic        logic_level_enable_input    = 1'b0;
  logic        reached = 1'b0;
  logic        ovTrip  = 1'b0;
  logic        jump    = 1'b0;
  logic [5:0]  reqCode = 6'h3F;
  logic [5:0]  codeW;
  pins_s       pinsW;
  bus_req_s    busReq  = '0;
  logic [31:0] rdData;
  logic        pwmOe_n;
  logic        powerGoodOutput;
  logic        ovLevelShutdown;
  logic [3:0]  rsOffset;
  logic [7:0]  refLevel;
  logic [31:0] d;
  int          fails   = 0;
  int          checks  = 0;

  always #2.5 mclk = ~mclk;

  assign pinsW = '{porValid: por, enThreshold: enTh, logicLevelEnableInput: logic_level_enable_input, refReachedOutput: reached,
                   outputInWindow: 1'b1, ovTrip: ovTrip, voltageCodeInput: codeW};

  // pre-biased output sits at level 0x0A
  always @(posedge mclk) reached <= (refLevel >= 8'h0A);

  code_source_model src_u (.mclk(mclk), .rst(rst), .reqCode(reqCode), .jump(jump), .code(codeW));

  vid_softstart_sequencer dut_u (.mclk(mclk), .rst(rst), .pins(pinsW), .busReq(busReq), .rdData(rdData),
    .pwmOe_n(pwmOe_n), .powerGoodOutput(powerGoodOutput), .ovLevelShutdown(ovLevelShutdown),
    .rsOffset(rsOffset), .refLevel(refLevel));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic close_out;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  function automatic logic inRange(input logic [15:0] v, input logic [15:0] lo, input logic [15:0] hi);
    return (v >= lo) && (v <= hi);
  endfunction

  task automatic wait_clk(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  task automatic bus_write(input logic [3:0] a, input logic [31:0] v);
    @(posedge mclk);
    busReq.addr     <= a;
    busReq.wrData   <= v;
    busReq.wrStrobe <= 1'b1;
    @(posedge mclk);
    busReq.wrStrobe <= 1'b0;
    #1;
  endtask

  task automatic bus_read(input logic [3:0] a, output logic [31:0] v);
    @(posedge mclk);
    busReq.addr     <= a;
    busReq.rdStrobe <= 1'b1;
    @(posedge mclk);
    busReq.rdStrobe <= 1'b0;
    #1;
    v = rdData;
  endtask

  task automatic set_code(input logic [5:0] c, input logic j);
    @(posedge mclk);
    reqCode <= c;
    jump    <= j;
    @(posedge mclk);
    jump    <= 1'b0;
    #1;
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_regs;
    check(32'({pwmOe_n, powerGoodOutput, refLevel}), 32'h200);
    bus_read(ADDR_CTRL, d);
    check(d, 32'h43);
    bus_read(4'hC, d);
    check(d, 32'h0);
    bus_write(ADDR_STATUS, 32'hFFFFFFFF);
    bus_write(ADDR_CTRL, 32'h2);
    bus_read(ADDR_CTRL, d);
    check(d, 32'h2);
    bus_read(ADDR_STATUS, d);
    check(d, 32'h0);
  endtask

  task automatic t_refuse;
    for (int i = 0; i < 4; i++)
    begin
      @(posedge mclk);
      reqCode <= (i == 3) ? CODE_OFF_B : 6'h0A;
      jump    <= 1'b1;
      @(posedge mclk);
      jump    <= 1'b0;
      wait_clk(10);
      @(posedge mclk);
      por     <= (i != 0);
      enTh    <= (i != 1);
      logic_level_enable_input    <= (i != 2);
      wait_clk(40);
      bus_read(ADDR_STATUS, d);
      check(32'({d[6:4], d[1:0]}), 32'h0);
      check(32'({pwmOe_n, powerGoodOutput}), 32'h2);
    end
  endtask

  task automatic t_softstart;
    int n;
    n = 0;
    @(posedge mclk);
    logic_level_enable_input    <= 1'b0;
    reqCode <= 6'h0A;
    jump    <= 1'b1;
    @(posedge mclk);
    jump    <= 1'b0;
    enTh    <= 1'b1;
    por     <= 1'b1;
    wait_clk(20);
    @(posedge mclk);
    logic_level_enable_input <= 1'b1;
    wait_clk(720);
    check(32'({refLevel, rsOffset, pwmOe_n}), 32'h11);
    wait_clk(1200);
    check(32'(pwmOe_n), 32'h1);
    wait_clk(2696);
    check(32'(inRange(16'(refLevel), 16'h12, 16'h16)), 32'h1);
    check(32'(inRange(16'(rsOffset), 16'h3, 16'h5)), 32'h1);
    check(32'(pwmOe_n), 32'h0);
    wait_clk(3928);
    check(32'(inRange(16'(refLevel), 16'h28, 16'h29)), 32'h1);
    check(32'(rsOffset), 32'h0);
    while (powerGoodOutput !== 1'b1 && n < 9000)
    begin
      wait_clk(1);
      n++;
    end
    check(32'(inRange(16'(8544 + n), 16'd15540, 16'd15600)), 32'h1);
    check(32'(refLevel), 32'h4D);
    check(32'(powerGoodOutput), 32'h1);
  endtask

  task automatic t_track;
    set_code(6'h08, 1'b0);
    for (int k = 0; k < 2; k++)
    begin
      for (int w = 0; w < 400 && codeW !== 6'(6'h09 - k); w++)
        wait_clk(1);
      wait_clk(5);
      check(32'(refLevel), 32'(8'h4D + k));
      wait_clk(30);
      check(32'(refLevel), 32'(8'h4E + k));
    end
    set_code(6'h07, 1'b1);
    wait_clk(2);
    set_code(6'h08, 1'b1);
    wait_clk(40);
    check(32'(refLevel), 32'h4F);
    set_code(6'h04, 1'b1);
    wait_clk(40);
    check(32'(refLevel), 32'h53);
  endtask

  task automatic t_noload;
    set_code(CODE_OFF_A, 1'b1);
    wait_clk(12);
    check(32'({powerGoodOutput, pwmOe_n, ovLevelShutdown}), 32'h0);
    wait_clk(48);
    check(32'({pwmOe_n, ovLevelShutdown}), 32'h3);
    bus_read(ADDR_STATUS, d);
    check(32'(d[6:4]), 32'h0);
    set_code(6'h0A, 1'b1);
    wait_clk(20);
    bus_read(ADDR_STATUS, d);
    check(32'(d[6:4]), 32'h2);
  endtask

  task automatic t_ovlatch;
    @(posedge mclk);
    ovTrip <= 1'b1;
    wait_clk(8);
    @(posedge mclk);
    ovTrip <= 1'b0;
    wait_clk(10);
    bus_read(ADDR_STATUS, d);
    check(32'({d[6:3], pwmOe_n}), 32'h3);
    set_code(CODE_OFF_A, 1'b1);
    wait_clk(60);
    set_code(6'h0A, 1'b1);
    wait_clk(60);
    bus_read(ADDR_STATUS, d);
    check(32'({d[6:3], powerGoodOutput}), 32'h2);
    @(posedge mclk);
    logic_level_enable_input <= 1'b0;
    wait_clk(10);
    @(posedge mclk);
    logic_level_enable_input <= 1'b1;
    wait_clk(20);
    bus_read(ADDR_STATUS, d);
    check(32'(d[6:3]), 32'h4);
  endtask

  // ----------------------------------------------------------------
  // main sequence and watchdog
  // ----------------------------------------------------------------
  initial
  begin
    repeat (8) @(posedge mclk);
    rst <= 1'b0;
    wait_clk(4);
    t_regs();
    t_refuse();
    t_softstart();
    t_track();
    t_noload();
    t_ovlatch();
    close_out();
  end

  initial
  begin
    #200000;
    fails++;
    close_out();
  end
endmodule
